// File: src/dfq_dual_fifo.sv
`timescale 1ns/10ps
// Function
// (RL1) The near-limit flag is high when the count is at or below the offset or at or above 1024 minus it.
// (RL2) The near-limit flag is low when the count lies from offset plus one to 1023 minus offset.
// (RL3) The second queue has its own flag and its own independently held offset.
// (RL4) Each queue picks its offset at its own clear: captured value or the default of 256.
// (RL5) A falling edge of a queue's offset strobe captures that queue's input data as the offset.
// (RL6) A low strobe when the queue clear ends selects the captured offset.
// (RL7) A high strobe when the queue clear ends selects the offset 256.
// (RL8) To load the second offset from port A the host drives the value, select low and enable high.
// (RL9) With that setting port A data feeds the second queue and a strobe fall stores it.
// (RL10) Reads may follow on every read clock edge without waiting for the previous one to settle.
// (RL11) The outside system keeps its write and read clocks at or below 50 MHz.
// (RL12) Each queue writes on write clock rising edges and reads in order on read clock edges.
// (RL13) The first word into an empty queue appears at the outputs and the ready flag goes high.
// (RL14) Writes while full and reads while empty change neither memory nor pointers.
module dfq_dual_fifo (
    // System
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Bus ports
    input  wire logic [dfq_pkg::DW-1:0] port_a_bits,
    input  wire logic [dfq_pkg::DW-1:0] port_b_bits,
    input  wire logic                   live_select_a_to_b,
    input  wire logic                   drive_enable_a_to_b,
    // First queue control, port A to port B
    input  wire logic                   write_clock_first,
    input  wire logic                   read_clock_first,
    input  wire logic                   offset_strobe_first_n,
    input  wire logic                   clear_first_queue_n,
    // Second queue control, port B to port A
    input  wire logic                   write_clock_second,
    input  wire logic                   read_clock_second,
    input  wire logic                   offset_strobe_second_n,
    input  wire logic                   clear_second_queue_n,
    // First queue status and data
    output logic      [dfq_pkg::DW-1:0] first_data_out,
    output logic                        first_ready,
    output logic                        first_full_n,
    output logic                        near_limit_flag_first,
    // Second queue status and data
    output logic      [dfq_pkg::DW-1:0] second_data_out,
    output logic                        second_ready,
    output logic                        second_full_n,
    output logic                        near_limit_flag_second
);
    import dfq_pkg::*;

    // Two-stage capture of every pin before use
    wire  [SYNC_W-1:0] raw = {port_a_bits, port_b_bits,
                              live_select_a_to_b, drive_enable_a_to_b,
                              write_clock_first, read_clock_first,
                              offset_strobe_first_n, clear_first_queue_n,
                              write_clock_second, read_clock_second,
                              offset_strobe_second_n, clear_second_queue_n};
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_pin;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_meta <= SYNC_RESET;
            sync_pin  <= SYNC_RESET;
        end else begin
            sync_meta <= raw;
            sync_pin  <= sync_meta;
        end
    end

    wire [DW-1:0]    s_port_a = sync_pin[POS_A +: DW];
    wire [DW-1:0]    s_port_b = sync_pin[POS_B +: DW];
    wire             s_sel    = sync_pin[POS_SEL];
    wire             s_en     = sync_pin[POS_EN];
    wire [CTL_W-1:0] ctl_now [2];
    assign ctl_now[0] = sync_pin[POS_CTL0 +: CTL_W];
    assign ctl_now[1] = sync_pin[POS_CTL1 +: CTL_W];

    // Port A reaches the second queue in the stored-select, drive-enabled setting
    wire             a_to_second = !s_sel && s_en;                        // [RL9]
    wire [DW-1:0]    q_din [2];
    assign q_din[0] = s_port_a;
    assign q_din[1] = a_to_second ? s_port_a : s_port_b;                  // [RL9]

    logic [1:0]    near_q;
    logic [1:0]    ready_q;
    logic [1:0]    full_n_q;
    logic [DW-1:0] dout [2];

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_queue
            logic [CTL_W-1:0] ctl_prev;
            dfq_state_t       state;
            logic [DW-1:0]    captured;
            logic [DW-1:0]    offset;
            logic [AW-1:0]    wptr;
            logic [AW-1:0]    rptr;
            logic [CW-1:0]    count;

            wire [CTL_W-1:0] c = ctl_now[i];
            // Edge detection on the second synchroniser stage only
            wire wr_edge  = c[CTL_WR] && !ctl_prev[CTL_WR];
            wire rd_edge  = c[CTL_RD] && !ctl_prev[CTL_RD];
            wire stb_fall = !c[CTL_STB] && ctl_prev[CTL_STB];
            wire clr_rise = c[CTL_CLR] && !ctl_prev[CTL_CLR];
            wire in_clear = !c[CTL_CLR];
            wire running  = (state == ST_RUN) && !in_clear;

            wire is_full  = (count == DEPTH);
            wire is_empty = (count == COUNT_RESET);
            wire do_wr    = running && wr_edge && !is_full;              // [RL12] [RL14]
            wire do_rd    = running && rd_edge && !is_empty;             // [RL10] [RL14]

            wire [CW-1:0] next_count = in_clear ? COUNT_RESET
                                     : CW'(count + CW'(do_wr) - CW'(do_rd));
            wire [AW-1:0] next_wptr  = in_clear ? PTR_RESET : AW'(wptr + AW'(do_wr));
            wire [AW-1:0] next_rptr  = in_clear ? PTR_RESET : AW'(rptr + AW'(do_rd));
            // Offset picked at the end of the queue clear
            wire [DW-1:0] next_offset = !clr_rise      ? offset
                                      : c[CTL_STB]     ? OFFSET_DEFAULT  // [RL7]
                                      : captured;                         // [RL4] [RL6]
            wire [CW-1:0] off_w      = CW'(next_offset);
            wire          next_near  = (next_count <= off_w)
                                    || (next_count >= CW'(DEPTH - off_w)); // [RL1] [RL2] [RL3]

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    ctl_prev <= CTL_RESET;
                end else begin
                    ctl_prev <= c;
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    state <= ST_CLEAR;
                end else begin
                    case (state)
                        ST_CLEAR: state <= clr_rise ? ST_RUN : ST_CLEAR;
                        ST_RUN:   state <= in_clear ? ST_CLEAR : ST_RUN;
                        default:  state <= ST_CLEAR;
                    endcase
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    captured <= DATA_RESET;
                end else if (stb_fall) begin
                    captured <= q_din[i];                                 // [RL5] [RL9]
                end
            end

            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    offset   <= OFFSET_DEFAULT;
                    wptr     <= PTR_RESET;
                    rptr     <= PTR_RESET;
                    count    <= COUNT_RESET;
                    near_q[i]   <= 1'b1;
                    ready_q[i]  <= 1'b0;
                    full_n_q[i] <= 1'b1;
                end else begin
                    offset   <= next_offset;
                    wptr     <= next_wptr;
                    rptr     <= next_rptr;
                    count    <= next_count;
                    near_q[i]   <= next_near;                             // [RL1] [RL2]
                    ready_q[i]  <= (next_count != COUNT_RESET);           // [RL13]
                    full_n_q[i] <= (next_count != DEPTH);
                end
            end

            // Head word tracks the next read pointer; fresh writes bypass
            dfq_mem u_mem (
                .clk   (clk),
                .rst   (rst),
                .we    (do_wr),
                .waddr (wptr),
                .wdata (q_din[i]),
                .raddr (next_rptr),
                .rdata (dout[i])
            );                                                            // [RL13]
        end
    endgenerate

    assign first_data_out         = dout[0];
    assign first_ready            = ready_q[0];
    assign first_full_n           = full_n_q[0];
    assign near_limit_flag_first  = near_q[0];
    assign second_data_out        = dout[1];
    assign second_ready           = ready_q[1];
    assign second_full_n          = full_n_q[1];
    assign near_limit_flag_second = near_q[1];
endmodule : dfq_dual_fifo

// File: common/dfq_pkg.sv
package dfq_pkg;
    // Queue geometry
    localparam int          DW        = 9;
    localparam int          AW        = 10;
    localparam int          CW        = 11;
    localparam logic [CW-1:0] DEPTH   = 11'h400;
    // Offset chosen when the strobe is high at the end of a queue clear
    localparam logic [DW-1:0] OFFSET_DEFAULT = 9'h100;
    // Reset values
    localparam logic [AW-1:0] PTR_RESET    = 10'h000;
    localparam logic [CW-1:0] COUNT_RESET  = 11'h000;
    localparam logic [DW-1:0] DATA_RESET   = 9'h000;
    // Synchroniser layout: {port a, port b, select, enable, ctl first, ctl second}
    localparam int          CTL_W     = 4;
    localparam int          SYNC_W    = 2 * DW + 2 + 2 * CTL_W;
    localparam int          POS_A     = SYNC_W - DW;
    localparam int          POS_B     = SYNC_W - 2 * DW;
    localparam int          POS_SEL   = 2 * CTL_W + 1;
    localparam int          POS_EN    = 2 * CTL_W;
    localparam int          POS_CTL0  = CTL_W;
    localparam int          POS_CTL1  = 0;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 28'h0000000;
    localparam logic [CTL_W-1:0]  CTL_RESET  = 4'h0;
    // Bit positions inside one control group
    localparam int          CTL_WR    = 3;
    localparam int          CTL_RD    = 2;
    localparam int          CTL_STB   = 1;
    localparam int          CTL_CLR   = 0;

    typedef enum logic {
        ST_CLEAR = 1'b0,
        ST_RUN   = 1'b1
    } dfq_state_t;
endpackage : dfq_pkg

// File: src/dfq_mem.sv
`timescale 1ns/10ps
module dfq_mem (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // Write side
    input  wire logic                   we,
    input  wire logic [dfq_pkg::AW-1:0] waddr,
    input  wire logic [dfq_pkg::DW-1:0] wdata,
    // Read side
    input  wire logic [dfq_pkg::AW-1:0] raddr,
    output logic      [dfq_pkg::DW-1:0] rdata
);
    import dfq_pkg::*;

    logic [DW-1:0] mem [0:(1 << AW) - 1];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Write-through so a word written to the head shows up at once
    wire hit = we && (waddr == raddr);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= DATA_RESET;
        end else begin
            rdata <= hit ? wdata : mem[raddr];
        end
    end
endmodule : dfq_mem

// File: tb/dfq_sva.sv
`timescale 1ns/10ps
module dfq_sva (
    // Clock and reset
    input wire logic       clk,
    input wire logic       rst,
    // Watched ports
    input wire logic       write_clock_first,
    input wire logic       read_clock_first,
    input wire logic       write_clock_second,
    input wire logic       clear_first_queue_n,
    input wire logic       clear_second_queue_n,
    input wire logic [8:0] first_data_out,
    input wire logic       first_ready,
    input wire logic       first_full_n,
    input wire logic       near_limit_flag_first,
    input wire logic       second_ready,
    input wire logic       near_limit_flag_second
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_first_held; !clear_first_queue_n [*4]; endsequence
    sequence s_second_held; !clear_second_queue_n [*4]; endsequence
    a_first_clear_empty: assert property (s_first_held |-> !first_ready && near_limit_flag_first)
        else $error("first queue not empty in clear");
    a_second_clear_empty: assert property (s_second_held |-> !second_ready && near_limit_flag_second)
        else $error("second queue not empty in clear");
    a_ready_by_write: assert property ($rose(first_ready) |-> $past(write_clock_first, 3))
        else $error("first ready without write");
    a_second_by_write: assert property ($rose(second_ready) |-> $past(write_clock_second, 3))
        else $error("second ready without write");
    a_empty_by_read: assert property ($fell(first_ready) && clear_first_queue_n |-> $past(read_clock_first, 3))
        else $error("first ready lost without read");
    a_head_by_read: assert property ($changed(first_data_out) && $past(first_ready) && clear_first_queue_n
        |-> $past(read_clock_first, 3))
        else $error("head word changed without read");
    a_full_holds_data: assert property (!first_full_n |-> first_ready && near_limit_flag_first)
        else $error("full queue flags wrong");
    a_full_left_read: assert property ($rose(first_full_n) && clear_first_queue_n |-> $past(read_clock_first, 3))
        else $error("full left without read");
endmodule : dfq_sva

bind dfq_dual_fifo dfq_sva u_sva (.*);

// File: tb/dfq_bus_pins.sv
`timescale 1ns/10ps
module dfq_bus_pins (
    // Clock
    input  wire logic       clk,
    // Requests and pin clocks: write first, read first, write second, read second
    input  wire logic [3:0] go,
    output logic      [3:0] pins
);
    logic [5:0] shape [4] = '{default: 6'h00};
    initial pins = 4'h0;
    // Rising edge 3 clk after a request, 4 clk high, far below 50 MHz
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            shape[i] <= go[i] ? 6'h3c : shape[i] >> 1;
            pins[i]  <= shape[i][0];
        end
    end
endmodule : dfq_bus_pins

// File: tb/dfq_dual_fifo_tb.sv
`timescale 1ns/10ps
module dfq_dual_fifo_tb;
    import dfq_pkg::*;
    logic          clk = 1'b0, rst = 1'b1;
    logic [DW-1:0] port_a_bits = 9'h000, port_b_bits = 9'h000;
    logic          live_select_a_to_b = 1'b1, drive_enable_a_to_b = 1'b0;
    logic          offset_strobe_first_n = 1'b1, offset_strobe_second_n = 1'b1;
    logic          clear_first_queue_n = 1'b0, clear_second_queue_n = 1'b0;
    logic [3:0]    go = 4'h0;
    wire logic [3:0] pins;
    logic [DW-1:0] first_data_out, second_data_out, q_first[$], q_second[$];
    logic          first_ready, first_full_n, near_limit_flag_first;
    logic          second_ready, second_full_n, near_limit_flag_second;
    integer        seed = 32'hb40f045b;
    int            n_mismatch = 0, total_checks = 0, off_b;

    dfq_dual_fifo u_dut (.*, .write_clock_first(pins[0]), .read_clock_first(pins[1]),
        .write_clock_second(pins[2]), .read_clock_second(pins[3]));
    dfq_bus_pins u_bus (.clk(clk), .go(go), .pins(pins));

    initial forever #25 clk = ~clk;

    task check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task pulse(input int k);
        @(negedge clk) go[k] = 1'b1;
        @(negedge clk) go[k] = 1'b0;
        repeat (10) @(negedge clk);
    endtask : pulse

    function automatic logic exp_near(input int c, input int o);
        return (c <= o) || (c >= 1024 - o);
    endfunction : exp_near

    task test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done

    // Head word is compared as each read edge reaches the pin
    initial forever @(posedge pins[1]) if (q_first.size() > 0) check(first_data_out, q_first.pop_front());
    initial forever @(posedge pins[3]) if (q_second.size() > 0) check(second_data_out, q_second.pop_front());

    initial begin
        repeat (40000) @(posedge clk);
        n_mismatch++;
        test_done;
    end

    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        off_b = $random(seed) & 32'h1f;
        port_a_bits = 9'(off_b);
        live_select_a_to_b = 1'b0;
        drive_enable_a_to_b = 1'b1;
        repeat (4) @(negedge clk);
        offset_strobe_second_n = 1'b0;
        repeat (4) @(negedge clk);
        clear_first_queue_n = 1'b1;
        clear_second_queue_n = 1'b1;
        repeat (6) @(negedge clk);
        live_select_a_to_b = 1'b1;
        offset_strobe_second_n = 1'b1;
        // Fill to full plus one refused write
        for (int i = 1; i <= 1025; i++) begin
            port_a_bits = 9'($random(seed));
            if (i <= 1024) q_first.push_back(port_a_bits);
            pulse(0);
            check(9'(near_limit_flag_first), 9'(exp_near(i > 1024 ? 1024 : i, 256)));
            check(9'(first_full_n), 9'(i < 1024));
        end
        // Drain to empty plus one refused read
        for (int i = 1023; i >= -1; i--) begin
            pulse(1);
            check(9'(near_limit_flag_first), 9'(exp_near(i < 0 ? 0 : i, 256)));
            check(9'(first_ready), 9'(i > 0));
        end
        for (int i = 1; i <= off_b + 2; i++) begin
            port_b_bits = 9'($random(seed));
            q_second.push_back(port_b_bits);
            pulse(2);
            check(9'(near_limit_flag_second), 9'(exp_near(i, off_b)));
            check(9'(second_full_n), 9'h001);
        end
        // Drain the second queue to empty at the same 12 clk pin spacing as the writes
        for (int i = off_b + 1; i >= 0; i--) begin
            pulse(3);
            check(9'(second_ready), 9'(i > 0));
            check(9'(near_limit_flag_second), 9'(exp_near(i, off_b)));
            check(9'(second_full_n), 9'h001);
        end
        test_done;
    end
endmodule : dfq_dual_fifo_tb
